//--- sepc_regs.svh
// Opcodes, status byte layout, reset values, frame lengths and timing of the command front end.
// Assumes it is included by its bare name wherever these constants are used.
`ifndef SEPC_REGS_SVH
`define SEPC_REGS_SVH
`define SEPC_OP_WRITE_ENABLE 8'h06
`define SEPC_OP_WRITE_DISABLE 8'h04
`define SEPC_OP_STATUS_READ 8'h05
`define SEPC_OP_STATUS_WRITE 8'h01
`define SEPC_OP_MEM_READ 8'h03
`define SEPC_OP_MEM_WRITE 8'h02
`define SEPC_SR_PIN_PROTECT 7
`define SEPC_SR_ID_SELECT 6
`define SEPC_SR_ZERO 5
`define SEPC_SR_ID_LOCK 4
`define SEPC_SR_BP_HIGH 3
`define SEPC_SR_BP_LOW 2
`define SEPC_SR_WRITE_LATCH 1
`define SEPC_SR_BUSY 0
`define SEPC_SR_RESET 8'h00
`define SEPC_QUARTER_BASE 14'h3000
`define SEPC_HALF_BASE 14'h2000
`define SEPC_CMD_BITS 6'h08
`define SEPC_STATUS_WRITE_BITS 6'h10
`define SEPC_ADDR_END_BITS 6'h18
`define SEPC_MEM_WRITE_BITS 6'h20
`define SEPC_COUNT_MAX 6'h3f
`define SEPC_WRITE_CYCLE_TIME_US 5000
`define SEPC_REF_CLK_MHZ 100
`endif

//--- sepc_pkg.sv
// Types of the serial EEPROM command front end: state encodings and state records.
// Assumes nothing of its surroundings.
package sepc_pkg;
  typedef enum logic [1:0] {
    SEPC_L_CMD = 2'b00,
    SEPC_L_BODY = 2'b01,
    SEPC_L_IGNORE = 2'b11
  } sepc_link_state_type;
  typedef enum logic {
    SEPC_C_IDLE = 1'b0,
    SEPC_C_BUSY = 1'b1
  } sepc_core_state_type;
  typedef struct packed {
    sepc_link_state_type state;
    logic [5:0] count;
    logic [7:0] opcode;
    logic [15:0] body;
    logic [7:0] out_shift;
    logic reading;
  } sepc_link_pos_type;
  typedef struct packed {
    logic so_bit;
    logic so_oe;
  } sepc_link_neg_type;
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    sepc_core_state_type state;
    logic [19:0] timer;
    logic pin_protect_enable;
    logic id_page_select;
    logic id_page_lock;
    logic [1:0] block_protect;
    logic write_enable_latch;
    logic [7:0] snapshot;
    logic standby;
  } sepc_core_type;
endpackage

//--- sepc_link_if.sv
// Carrier between the serial clock logic and the core.
// Assumes the frame words are read by the core only after chip select has risen.
`timescale 1ns/1ns
interface sepc_link_if;
  logic [7:0] opcode;
  logic [15:0] body;
  logic [5:0] count;
  logic [7:0] snapshot;
  modport link (output opcode, output body, output count, input snapshot);
  modport core (input opcode, input body, input count, output snapshot);
endinterface

//--- sepc_link.sv
// Serial clock side of the front end: opcode and body capture, status shift out.
// Assumes si and hold_n meet setup and hold to the serial clock, and a frozen status snapshot.
`timescale 1ns/1ns
module sepc_link (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  sepc_link_if.link bus,
  output logic so_bit,
  output logic so_oe
);
  `include "sepc_regs.svh"

  sepc_pkg::sepc_link_pos_type pos, next_pos, base;
  sepc_pkg::sepc_link_neg_type neg, next_neg;
  logic fresh;

  function automatic logic op_defined(input logic [7:0] op);
    case (op)
      `SEPC_OP_WRITE_ENABLE, `SEPC_OP_WRITE_DISABLE, `SEPC_OP_STATUS_WRITE: op_defined = 1'b1;
      `SEPC_OP_STATUS_READ, `SEPC_OP_MEM_READ, `SEPC_OP_MEM_WRITE: op_defined = 1'b1;
      default: op_defined = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // A frame starts on the falling select; no serial clock edge exists in between.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh <= 1'b1;
    end else if (hold_n) begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    base = pos;
    if (fresh) begin
      base.state = sepc_pkg::SEPC_L_CMD;
      base.count = 6'h00;
      base.opcode = 8'h00;
      base.reading = 1'b0;
    end
    next_pos = base;
    if (hold_n) begin
      if (base.count != `SEPC_COUNT_MAX) begin
        next_pos.count = base.count + 6'h01;
      end
      case (base.state)
        sepc_pkg::SEPC_L_CMD: begin
          next_pos.opcode = {base.opcode[6:0], si};
          if (base.count == `SEPC_CMD_BITS - 6'h01) begin
            if (!op_defined(next_pos.opcode)) begin
              next_pos.state = sepc_pkg::SEPC_L_IGNORE;
            end else if (bus.snapshot[`SEPC_SR_BUSY] &&
                next_pos.opcode != `SEPC_OP_STATUS_READ) begin
              next_pos.state = sepc_pkg::SEPC_L_IGNORE;
            end else begin
              next_pos.state = sepc_pkg::SEPC_L_BODY;
              next_pos.reading = (next_pos.opcode == `SEPC_OP_STATUS_READ);
              next_pos.out_shift = bus.snapshot;
            end
          end
        end
        sepc_pkg::SEPC_L_BODY: begin
          if (base.count < `SEPC_ADDR_END_BITS) begin
            next_pos.body = {base.body[14:0], si};
          end
          if (base.reading) begin
            next_pos.out_shift = {base.out_shift[6:0], base.out_shift[7]};
          end
        end
        sepc_pkg::SEPC_L_IGNORE: begin
          next_pos.reading = 1'b0;
        end
        default: begin
          next_pos.state = sepc_pkg::SEPC_L_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge sck) begin
    pos <= next_pos;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The output moves on the falling edge, so the host samples it on the next rising edge.
  always_comb begin
    next_neg.so_bit = pos.out_shift[7];
    next_neg.so_oe = hold_n && !fresh && pos.reading &&
        (pos.state == sepc_pkg::SEPC_L_BODY);
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      neg <= '0;
    end else begin
      neg <= next_neg;
    end
  end

  assign so_bit = neg.so_bit;
  assign so_oe = neg.so_oe;
  assign bus.opcode = pos.opcode;
  assign bus.body = pos.body;
  assign bus.count = pos.count;
endmodule // sepc_link

//--- sepc_guard.sv
// Write permission: decides whether a status write or a memory write may proceed.
// Assumes all inputs are stable levels of the reference clock domain.
`timescale 1ns/1ns
module sepc_guard (
  input wire logic [1:0] block_protect,
  input wire logic write_enable_latch,
  input wire logic pin_protect_enable,
  input wire logic wp_level,
  input wire logic id_page_select,
  input wire logic id_page_lock,
  input wire logic [13:0] address,
  output logic status_ok,
  output logic memory_ok
);
  `include "sepc_regs.svh"

  function automatic logic in_protected(input logic [1:0] bp, input logic [13:0] a);
    case (bp)
      2'b00: in_protected = 1'b0;
      2'b01: in_protected = (a >= `SEPC_QUARTER_BASE);
      2'b10: in_protected = (a >= `SEPC_HALF_BASE);
      default: in_protected = 1'b1;
    endcase
  endfunction

  always_comb begin
    status_ok = write_enable_latch && !(pin_protect_enable && !wp_level);
    memory_ok = write_enable_latch && !in_protected(block_protect, address) &&
        !(id_page_select && id_page_lock);
  end
endmodule // sepc_guard

//--- sepc_top.sv
// Command front end of a serial EEPROM: pin synchronisers, status byte, write cycle timer.
// Assumes a host on the four-wire port in mode (0,0) or (1,1) and a free-running ref_clk.
// Function
// - Serial input is sampled on every rising serial clock edge while hold_n is high, both modes.
// - Serial output changes on every falling serial clock edge.
// - Select high tri-states the output; standby unless a write cycle runs.
// - First eight bits fill the opcode; only six defined opcodes act.
// - Opcodes 06 write enable, 04 write disable, 01 status write.
// - Opcodes 05 status read, 03 memory read, 02 memory write.
// - Status byte layout fixed; bit 5 always reads zero.
// - Busy is one during the write cycle, zero after; host cannot write it.
// - Write enable command sets the latch; write disable command clears it.
// - Block protect changes only by status write and makes covered addresses read-only.
// - Protect codes cover none, upper quarter, upper half, or whole array.
// - Pin low with pin-protect enable refuses status writes.
// - Latch clear blocks all writes; set allows unprotected memory and permitted status.
// - Id page select steers one access to the id page, then clears.
// - Id page lock, once set, blocks every id page write.
// - Status write setting both select and lock leaves both unchanged.
// - Writing starts disabled; host sets the latch before any write.
// - Write cycle starts at the rising select ending a valid write.
// - During the write cycle only status read is served.
// - End of the write cycle clears the write enable latch.
`timescale 1ns/1ns
`include "sepc_regs.svh"
module sepc_top #(
  parameter int unsigned WRITE_CYCLES = `SEPC_WRITE_CYCLE_TIME_US * `SEPC_REF_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic spi_so,
  output logic spi_so_oe,
  output logic standby
);

  localparam logic [19:0] LAST_TICK = 20'(WRITE_CYCLES - 1);
  localparam sepc_pkg::sepc_core_type CORE_RESET = '{
    cs_meta: 1'b1,
    cs_sync: 1'b1,
    cs_prev: 1'b1,
    wp_meta: 1'b1,
    wp_sync: 1'b1,
    state: sepc_pkg::SEPC_C_IDLE,
    timer: 20'h00000,
    pin_protect_enable: 1'b0,
    id_page_select: 1'b0,
    id_page_lock: 1'b0,
    block_protect: 2'b00,
    write_enable_latch: 1'b0,
    snapshot: `SEPC_SR_RESET,
    standby: 1'b1
  };

  sepc_pkg::sepc_core_type st, next_st;
  sepc_link_if bus ();
  logic frame_end;
  logic idle;
  logic status_ok;
  logic memory_ok;
  logic [7:0] status_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock domain.
  sepc_link u_link (
    .sck(spi_sck),
    .cs_n(spi_cs_n),
    .si(spi_si),
    .hold_n(hold_n),
    .bus(bus.link),
    .so_bit(spi_so),
    .so_oe(spi_so_oe)
  );

  sepc_guard u_guard (
    .block_protect(st.block_protect),
    .write_enable_latch(st.write_enable_latch),
    .pin_protect_enable(st.pin_protect_enable),
    .wp_level(st.wp_sync),
    .id_page_select(st.id_page_select),
    .id_page_lock(st.id_page_lock),
    .address(bus.body[13:0]),
    .status_ok(status_ok),
    .memory_ok(memory_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reference clock domain.
  always_comb begin
    status_byte = `SEPC_SR_RESET;
    status_byte[`SEPC_SR_PIN_PROTECT] = st.pin_protect_enable;
    status_byte[`SEPC_SR_ID_SELECT] = st.id_page_select;
    status_byte[`SEPC_SR_ZERO] = 1'b0;
    status_byte[`SEPC_SR_ID_LOCK] = st.id_page_lock;
    status_byte[`SEPC_SR_BP_HIGH] = st.block_protect[1];
    status_byte[`SEPC_SR_BP_LOW] = st.block_protect[0];
    status_byte[`SEPC_SR_WRITE_LATCH] = st.write_enable_latch;
    status_byte[`SEPC_SR_BUSY] = (st.state == sepc_pkg::SEPC_C_BUSY);
  end

  // Frame words are only read here, after the synchronised select has risen.
  assign frame_end = st.cs_sync && !st.cs_prev;
  assign idle = (st.state == sepc_pkg::SEPC_C_IDLE);
  assign bus.snapshot = st.snapshot;

  always_comb begin
    next_st = st;
    next_st.cs_meta = spi_cs_n;
    next_st.cs_sync = st.cs_meta;
    next_st.cs_prev = st.cs_sync;
    next_st.wp_meta = wp_n;
    next_st.wp_sync = st.wp_meta;
    next_st.standby = st.cs_sync && idle;
    // The snapshot freezes through a frame, so the serial side reads a stable word.
    if (st.cs_sync) begin
      next_st.snapshot = status_byte;
    end
    case (st.state)
      sepc_pkg::SEPC_C_IDLE: begin
        if (frame_end) begin
          case (bus.opcode)
            `SEPC_OP_WRITE_ENABLE: begin
              if (bus.count == `SEPC_CMD_BITS) begin
                next_st.write_enable_latch = 1'b1;
              end
            end
            `SEPC_OP_WRITE_DISABLE: begin
              if (bus.count == `SEPC_CMD_BITS) begin
                next_st.write_enable_latch = 1'b0;
              end
            end
            `SEPC_OP_STATUS_WRITE: begin
              if (bus.count == `SEPC_STATUS_WRITE_BITS && status_ok) begin
                next_st.pin_protect_enable = bus.body[`SEPC_SR_PIN_PROTECT];
                next_st.block_protect = bus.body[`SEPC_SR_BP_HIGH:`SEPC_SR_BP_LOW];
                if (!(bus.body[`SEPC_SR_ID_SELECT] && bus.body[`SEPC_SR_ID_LOCK])) begin
                  next_st.id_page_select = bus.body[`SEPC_SR_ID_SELECT];
                  next_st.id_page_lock = st.id_page_lock | bus.body[`SEPC_SR_ID_LOCK];
                end
                next_st.state = sepc_pkg::SEPC_C_BUSY;
                next_st.timer = 20'h00000;
              end
            end
            `SEPC_OP_MEM_READ: begin
              if (bus.count >= `SEPC_ADDR_END_BITS) begin
                next_st.id_page_select = 1'b0;
              end
            end
            `SEPC_OP_MEM_WRITE: begin
              if (bus.count >= `SEPC_MEM_WRITE_BITS) begin
                next_st.id_page_select = 1'b0;
                if (memory_ok) begin
                  next_st.state = sepc_pkg::SEPC_C_BUSY;
                  next_st.timer = 20'h00000;
                end
              end
            end
            default: begin
              next_st.state = sepc_pkg::SEPC_C_IDLE;
            end
          endcase
        end
      end
      sepc_pkg::SEPC_C_BUSY: begin
        // Frames that end during the cycle are dropped, which leaves only status reads.
        if (st.timer == LAST_TICK) begin
          next_st.state = sepc_pkg::SEPC_C_IDLE;
          next_st.write_enable_latch = 1'b0;
        end else begin
          next_st.timer = st.timer + 20'h00001;
        end
      end
      default: begin
        next_st.state = sepc_pkg::SEPC_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= CORE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign standby = st.standby;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_wel_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_WRITE_ENABLE && bus.count == `SEPC_CMD_BITS)
        |=> st.write_enable_latch ##1 st.write_enable_latch;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("Latch not set by enable.");

  property p_wel_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_WRITE_DISABLE && bus.count == `SEPC_CMD_BITS)
        |=> !st.write_enable_latch;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("Latch not cleared by disable.");

  property p_cycle_end;
    @(posedge ref_clk) disable iff (!rst_n)
    (!idle && st.timer == LAST_TICK) |=> idle && !st.write_enable_latch && !st.snapshot[5];
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("Write cycle end wrong.");

  property p_busy_runs;
    @(posedge ref_clk) disable iff (!rst_n)
    (!idle && st.timer != LAST_TICK) |=> !idle && st.timer == $past(st.timer) + 20'h00001;
  endproperty
  a_busy_runs: assert property (p_busy_runs) else $error("Busy ended early.");

  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_STATUS_WRITE &&
        bus.count == `SEPC_STATUS_WRITE_BITS && status_ok) |=> !idle && st.timer == 20'h00000;
  endproperty
  a_start: assert property (p_start) else $error("Write cycle did not start.");

  property p_ignore_busy;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && !idle && st.timer != LAST_TICK) |=>
        $stable(st.block_protect) && $stable(st.id_page_select) && $stable(st.write_enable_latch);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("Command acted while busy.");

  property p_pin_protect;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_STATUS_WRITE &&
        st.pin_protect_enable && !st.wp_sync) |=> idle && $stable(st.block_protect);
  endproperty
  a_pin_protect: assert property (p_pin_protect) else $error("Status write not refused.");

  property p_no_latch;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && !st.write_enable_latch) |=> idle [*2];
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("Write ran without latch.");

  property p_both_ids;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_STATUS_WRITE && status_ok &&
        bus.count == `SEPC_STATUS_WRITE_BITS && bus.body[6] && bus.body[4])
        |=> $stable(st.id_page_select) && $stable(st.id_page_lock);
  endproperty
  a_both_ids: assert property (p_both_ids) else $error("Select and lock changed together.");

  property p_id_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_MEM_READ && bus.count >= `SEPC_ADDR_END_BITS)
        |=> !st.id_page_select;
  endproperty
  a_id_clear: assert property (p_id_clear) else $error("Id page select kept after read.");

  property p_lock;
    @(posedge ref_clk) disable iff (!rst_n)
    (frame_end && idle && bus.opcode == `SEPC_OP_MEM_WRITE && st.id_page_select &&
        st.id_page_lock) |=> idle;
  endproperty
  a_lock: assert property (p_lock) else $error("Locked id page was written.");

  property p_standby;
    @(posedge ref_clk) disable iff (!rst_n)
    (!st.cs_sync) |=> !standby;
  endproperty
  a_standby: assert property (p_standby) else $error("Standby while selected.");
endmodule // sepc_top

//--- sepc_host.sv
// Host model for the four-wire port: drives select, serial clock, data in and pause.
// Assumes 80 ns serial clock periods and a device that answers on falling clock edges.
`timescale 1ns/1ns
module sepc_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    // The link has no reset, so one rising select edge clears it before any use.
    cs_n = 1'b0;
    #1 cs_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sends the top nbits of word; rx keeps the last eight bits seen on the wire.
  // The odd start delay keeps the serial edges out of step with the core clock.
  task automatic frame(input logic [31:0] word, input int nbits, input bit mode,
                       input int pause_at, output logic [7:0] rx, output logic oe_seen);
    rx = 8'h00;
    oe_seen = 1'b0;
    sck = mode;
    #7;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      if (i == pause_at) begin
        hold_n = 1'b0;
        #40 sck = 1'b1;
        #40 sck = 1'b0;
        #20 hold_n = 1'b1;
      end
      si = word[31 - i];
      #40 sck = 1'b1;
      rx = {rx[6:0], so};
      oe_seen = oe_seen | so_oe;
      #40;
    end
    sck = mode;
    #40 cs_n = 1'b1;
    // A released data line must not look like the last bit sent.
    si = ~si;
    #100;
  endtask
endmodule // sepc_host

//--- tb.sv
// Self-checking bench of the command front end with a host model on the serial port.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/1ns
module tb;
  localparam int unsigned CYC = 400;
  logic ref_clk, rst_n, wp_n, spi_sck, spi_cs_n, spi_si, hold_n;
  logic spi_so, spi_so_oe, standby, so_wire, oe_seen;
  logic [7:0] rx, op;
  logic [15:0] addr;
  logic [13:0] corner [4] = '{14'h1fff, 14'h2000, 14'h2fff, 14'h3000};
  int n_mismatch = 0;
  int check_count = 0;
  integer seed = 32'hf658d7fd;
  assign so_wire = spi_so_oe ? spi_so : 1'bz;
  sepc_top #(.WRITE_CYCLES(CYC)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .hold_n(hold_n), .wp_n(wp_n), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .standby(standby));
  sepc_host host (.sck(spi_sck), .cs_n(spi_cs_n), .si(spi_si), .hold_n(hold_n),
    .so(so_wire), .so_oe(spi_so_oe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic send(input logic [31:0] w, input int n);
    host.frame(w, n, 1'($random(seed)), -1, rx, oe_seen);
  endtask
  task automatic sr_is(input logic [7:0] exp);
    send(32'h0500_0000, 16);
    check(rx, exp);
  endtask
  // Polls the busy bit a bounded number of times; running out ends the run.
  task automatic wait_ready();
    for (int i = 0; i < 20; i++) begin
      send(32'h0500_0000, 16);
      if (rx[0] === 1'b0) return;
    end
    check(rx & 8'h01, 8'h00);
    final_report();
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    send(32'h0600_0000, 8);
    send({8'h01, v, 16'h0000}, 16);
  endtask
  function automatic logic [7:0] mem_status(input logic [1:0] bp, input logic [13:0] a);
    logic hit;
    hit = (bp == 2'b11) || (bp == 2'b10 && a >= 14'h2000) || (bp == 2'b01 && a >= 14'h3000);
    return {4'h0, bp, 1'b1, ~hit};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check({7'h00, standby}, 8'h01);
    check({7'h00, spi_so_oe}, 8'h00);
    sr_is(8'h00);
    $display("test reset done");
    host.frame(32'h0600_0000, 8, 1'b0, 3, rx, oe_seen);
    sr_is(8'h02);
    send(32'h0400_0000, 8);
    sr_is(8'h00);
    send({8'h01, 8'h8c, 16'h0000}, 16);
    sr_is(8'h00);
    $display("test latch done");
    status_write_cmd(8'h8c);
    sr_is(8'h8f);
    check({7'h00, standby}, 8'h00);
    send({8'h01, 8'h00, 16'h0000}, 16);
    wait_ready();
    sr_is(8'h8c);
    $display("test status write done");
    @(negedge ref_clk);
    wp_n = 1'b0;
    status_write_cmd(8'h00);
    sr_is(8'h8e);
    @(negedge ref_clk);
    wp_n = 1'b1;
    status_write_cmd(8'h00);
    wait_ready();
    sr_is(8'h00);
    $display("test pin protect done");
    status_write_cmd(8'h50);
    wait_ready();
    sr_is(8'h00);
    status_write_cmd(8'h40);
    wait_ready();
    sr_is(8'h40);
    send(32'h0312_3400, 24);
    check({7'h00, oe_seen}, 8'h00);
    sr_is(8'h00);
    $display("test id page done");
    send(32'h0200_0000, 32);
    sr_is(8'h00);
    for (int bp = 0; bp < 4; bp++) begin
      status_write_cmd({4'h0, 2'(bp), 2'b00});
      wait_ready();
      for (int k = 0; k < 5; k++) begin
        addr = (k < 4) ? {2'($random(seed)), corner[k]} : 16'($random(seed));
        send(32'h0600_0000, 8);
        send({8'h02, addr, 8'($random(seed))}, 32);
        sr_is(mem_status(2'(bp), addr[13:0]));
        if (rx[0] === 1'b1) begin
          wait_ready();
        end else begin
          send(32'h0400_0000, 8);
        end
      end
    end
    status_write_cmd(8'h00);
    wait_ready();
    $display("test block protect done");
    // Low three bits all set never match a defined opcode.
    for (int k = 0; k < 6; k++) begin
      op = {5'($random(seed)), 3'b111};
      send({op, 24'hffffff}, 16);
      check({7'h00, oe_seen}, 8'h00);
    end
    sr_is(8'h00);
    $display("test undefined opcode done");
    status_write_cmd(8'h10);
    wait_ready();
    status_write_cmd(8'h40);
    wait_ready();
    sr_is(8'h50);
    send(32'h0600_0000, 8);
    send(32'h0200_0000, 32);
    sr_is(8'h12);
    $display("test id page lock done");
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check({7'h00, standby}, 8'h01);
    check({7'h00, spi_so_oe}, 8'h00);
    sr_is(8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule // tb
